// *** src/dag_pkg.sv ***
// Shared constants and types for the data address generation block
package dag_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and counts
	localparam int ADDR_W = 12;
	localparam int BYTE_W = 8;
	localparam int HI_W   = 4;
	localparam int BANK_W = 4;
	localparam int NPTR   = 3;
	localparam int NVOP   = 5;
	localparam int PAIR_2 = 2;

	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [BYTE_W-1:0] byte_t;

	// Virtual operand kinds, one-hot
	typedef enum logic [4:0] {
		VM_PLAIN   = 5'h01,
		VM_PTR_AFTER_INCREMENT_OPERAND = 5'h02,
		VM_PTR_AFTER_DECREMENT_OPERAND = 5'h04,
		VM_PTR_BEFORE_INCREMENT_OPERAND  = 5'h08,
		VM_PTR_PLUS_WORKING_OPERAND   = 5'h10
	} vmode_t;

	// Request kinds from the decoder, one-hot
	typedef enum logic [2:0] {
		KIND_NONE = 3'h1,
		KIND_FILE = 3'h2,
		KIND_EXT  = 3'h4
	} kind_t;

	// Result of matching an address against the virtual operand locations
	typedef struct packed {
		logic       hit;
		logic [1:0] pair;
		vmode_t     mode;
	} vhit_t;

	////////////////////////////////////////////////////////////////////////////////
	// SFR map of the pointer pairs and their virtual operands
	localparam addr_t  VIRT_BASE [NPTR] = '{12'hfef, 12'hfe7, 12'hfdf};
	localparam addr_t  VOP_OFS [NVOP]   = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004};
	localparam vmode_t VOP_MODE [NVOP]  = '{VM_PLAIN, VM_PTR_AFTER_INCREMENT_OPERAND, VM_PTR_AFTER_DECREMENT_OPERAND, VM_PTR_BEFORE_INCREMENT_OPERAND, VM_PTR_PLUS_WORKING_OPERAND};
	localparam addr_t  PTR_HI_OFS       = 12'h005;
	localparam addr_t  PTR_LO_OFS       = 12'h006;
	localparam addr_t  ADDR_WORK        = 12'hfe8;
	localparam addr_t  ADDR_BANK        = 12'hfe0;
	localparam addr_t  ADDR_NONE        = 12'h000;
	localparam addr_t  ADDR_ONE         = 12'h001;

	// File field mapping
	localparam byte_t      ILO_LIMIT   = 8'h5f;
	localparam byte_t      FORCED_LOW  = 8'h60;
	localparam logic [3:0] FORCED_PAGE = 4'hf;
	localparam logic [3:0] ACCESS_PAGE = 4'h0;

	// Opcode fields of byte and bit instructions
	localparam int         OP_D_BIT   = 9;
	localparam int         OP_A_BIT   = 8;
	localparam int         OP_F_MSB   = 7;
	localparam int         OP_GRP_MSB = 15;
	localparam int         OP_GRP_LSB = 10;
	localparam logic [5:0] OP_ADD_GRP = 6'h09;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus map
	localparam logic [7:0]  REG_PTR [NPTR] = '{8'h00, 8'h04, 8'h08};
	localparam logic [7:0]  REG_BANK       = 8'h0c;
	localparam logic [7:0]  REG_WORK       = 8'h10;
	localparam logic [7:0]  REG_CTRL       = 8'h14;
	localparam logic [7:0]  REG_LAST       = 8'h18;
	localparam int          CTRL_EXT_BIT   = 0;
	localparam int          LANE_LO        = 0;
	localparam int          LANE_HI        = 1;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam byte_t       BYTE_ZERO      = 8'h00;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

endpackage : dag_pkg

// *** src/dag_ptr_step.sv ***
// Pointer stepping for the virtual operands of one pointer pair
`timescale 1ns/1ps
module dag_ptr_step
	import dag_pkg::*;
(
	input  wire addr_t  i_ptr,     // Current pointer pair value
	input  wire vmode_t i_mode,    // Virtual operand kind
	input  wire byte_t  i_work,    // Working register
	output addr_t       o_target,  // Address used by the access
	output addr_t       o_next     // Value stored back into the pair
);

	addr_t inc;
	addr_t dec;
	addr_t plus;

	// Whole-pair arithmetic, wraps in 12 bits, touches no status flag
	assign inc  = i_ptr + ADDR_ONE;
	assign dec  = i_ptr - ADDR_ONE;
	assign plus = i_ptr + {{HI_W{i_work[BYTE_W-1]}}, i_work};

	// Target and stored value per operand kind
	always_comb
	begin
		o_target = i_ptr;
		o_next   = i_ptr;
		unique case (i_mode)
			VM_PLAIN:   o_next = i_ptr;
			VM_PTR_AFTER_DECREMENT_OPERAND: o_next = dec;
			VM_PTR_AFTER_INCREMENT_OPERAND: o_next = inc;
			VM_PTR_BEFORE_INCREMENT_OPERAND:
			begin
				o_target = inc;
				o_next   = inc;
			end
			VM_PTR_PLUS_WORKING_OPERAND:   o_target = plus;
		endcase
	end

endmodule : dag_ptr_step

// *** src/dag_file_map.sv ***
// Mapping of an instruction file field onto a 12-bit data address
`timescale 1ns/1ps
module dag_file_map
	import dag_pkg::*;
(
	input  wire byte_t             i_file,  // File field of the opcode
	input  wire logic              i_a,     // Access-select bit
	input  wire logic              i_ext,   // Extended set enabled
	input  wire logic [BANK_W-1:0] i_bank,  // Bank select register
	input  wire addr_t             i_base,  // Pointer pair 2
	output addr_t                  o_ea     // First-level address
);

	// Banked, indexed, forced upper or low access bank
	always_comb
	begin
		if (i_a)
			o_ea = {i_bank, i_file};
		else if (i_ext && i_file <= ILO_LIMIT)
			o_ea = i_base + {ACCESS_PAGE, i_file};
		else if (i_file >= FORCED_LOW)
			o_ea = {FORCED_PAGE, i_file};
		else
			o_ea = {ACCESS_PAGE, i_file};
	end

endmodule : dag_file_map

// *** src/data_address_generation.sv ***
// Data address generation: pointer pairs, virtual operands and file mapping
// How it works
// - After-decrement operand: use pointer, then subtract one
// - After-increment operand: use pointer, then add one
// - Before-increment operand: add one, then use it
// - Plus-working operand: pointer plus signed working, unchanged
// - Plain operand uses pointer, leaves it unchanged
// - Steps carry or borrow across the whole pair
// - Pointer steps never touch any status flag
// - Indirect read of a virtual location returns zero
// - Indirect write of a virtual location does nothing
// - Write to own pair via operand: no step
// - Pairs are ordinary SFRs; indirect reaches other SFRs
// - Extended set enables five extra two-word instructions
// - Extended set leaves map and pairs 0,1 alone
// - Extended, a=0, file<=5Fh: pair 2 plus file
// - a=0, file>=60h: forced upper page F60h-FFFh
// - a=1: bank select register joined with file field
// - Inherent and literal instructions unaffected by extended set
// - Low access window spans pair 2 to plus 95
// - Named virtual operands keep standard indirect behaviour
// - Add opcode holds d and a above file field
// - Pair is 8-bit low plus 4 used high bits
// - Destination bit one: file, zero: working register
// - Indirect addresses ignore bank select and access bit
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module data_address_generation
	import dag_pkg::*;
(
	input  wire logic        i_clk,         // Core clock, 125 MHz
	input  wire logic        i_arst_n,      // Asynchronous reset, active low
	input  wire logic        i_acc_valid,   // Decoder presents an instruction
	input  wire kind_t       i_acc_kind,    // Instruction class
	input  wire logic [15:0] i_acc_opcode,  // First opcode word
	input  wire logic        i_acc_write,   // Instruction writes its target
	input  wire logic        i_wb_valid,    // Execute writes an SFR
	input  wire addr_t       i_wb_addr,     // Write-back address
	input  wire byte_t       i_wb_data,     // Write-back data
	output logic             o_rsp_valid,   // Answer for last instruction
	output addr_t            o_rsp_addr,    // Effective address
	output logic             o_rsp_mem,     // Access goes to data RAM
	output logic             o_rsp_local,   // Target is a local SFR
	output logic             o_rsp_null,    // Virtual target: read zero, no write
	output logic             o_rsp_we,      // Access writes its target
	output byte_t            o_rsp_data,    // Local SFR or null read data
	output logic             o_rsp_to_file, // Result goes back to file
	output logic             o_rsp_illegal, // Extended op with set disabled
	output logic             o_rsp_add,     // Opcode is add working to file
	input  wire logic        i_awvalid,     // AXI write address valid
	output logic             o_awready,     // AXI write address ready
	input  wire logic [7:0]  i_awaddr,      // AXI write address
	input  wire logic        i_wvalid,      // AXI write data valid
	output logic             o_wready,      // AXI write data ready
	input  wire logic [31:0] i_wdata,       // AXI write data
	input  wire logic [3:0]  i_wstrb,       // AXI write strobes
	output logic             o_bvalid,      // AXI write response valid
	input  wire logic        i_bready,      // AXI write response ready
	output logic [1:0]       o_bresp,       // AXI write response
	input  wire logic        i_arvalid,     // AXI read address valid
	output logic             o_arready,     // AXI read address ready
	input  wire logic [7:0]  i_araddr,      // AXI read address
	output logic             o_rvalid,      // AXI read data valid
	input  wire logic        i_rready,      // AXI read data ready
	output logic [31:0]      o_rdata,       // AXI read data
	output logic [1:0]       o_rresp        // AXI read response
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		addr_t [NPTR-1:0]  ptr;
		logic [BANK_W-1:0] bank;
		byte_t             work;
		logic              ext_en;
		addr_t             last_ea;
		logic              rsp_valid;
		addr_t             rsp_addr;
		logic              rsp_mem, rsp_local, rsp_null, rsp_we;
		byte_t             rsp_data;
		logic              rsp_to_file, rsp_illegal, rsp_add;
		logic              awready, wready, arready, aw_got, w_got, bvalid, rvalid;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic [1:0]        bresp, rresp;
		logic [31:0]       rdata;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	logic        op_d;
	logic        op_a;
	byte_t       op_file;
	addr_t       first_ea;
	vhit_t       vm_first;
	vhit_t       vm_second;
	addr_t       sel_ptr;
	addr_t       step_target;
	addr_t       step_next;
	logic        req_file;
	logic        ind;
	logic        own_hit;
	logic        upd_en;
	addr_t       eff_ea;
	logic        eff_null;
	logic [8:0]  loc;
	logic        axi_wr_fire;
	logic        hw_quiet;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic addr_t ptr_lo_addr(input int n);
		return VIRT_BASE[n] - PTR_LO_OFS;
	endfunction : ptr_lo_addr

	function automatic addr_t ptr_hi_addr(input int n);
		return VIRT_BASE[n] - PTR_HI_OFS;
	endfunction : ptr_hi_addr

	// Match an address against every virtual operand location
	function automatic vhit_t virt_decode(input addr_t a);
		vhit_t v;
		v = '{hit: 1'b0, pair: 2'h0, mode: VM_PLAIN};
		for (int n = 0; n < NPTR; n++)
			for (int m = 0; m < NVOP; m++)
				if (a == VIRT_BASE[n] - VOP_OFS[m])
					v = '{hit: 1'b1, pair: 2'(n), mode: VOP_MODE[m]};
		return v;
	endfunction : virt_decode

	// Local SFR read: hit flag above the byte
	function automatic logic [8:0] local_read(input addr_t a);
		logic [8:0] r;
		r = {1'b0, BYTE_ZERO};
		for (int n = 0; n < NPTR; n++)
		begin
			if (a == ptr_lo_addr(n))
				r = {1'b1, s_q.ptr[n][BYTE_W-1:0]};
			if (a == ptr_hi_addr(n))
				r = {1'b1, {(BYTE_W-HI_W){1'b0}}, s_q.ptr[n][ADDR_W-1:BYTE_W]};
		end
		if (a == ADDR_WORK)
			r = {1'b1, s_q.work};
		if (a == ADDR_BANK)
			r = {1'b1, {(BYTE_W-BANK_W){1'b0}}, s_q.bank};
		return r;
	endfunction : local_read

	// Local SFR write from the execute stage
	function automatic state_t local_write(input state_t s, input addr_t a, input byte_t d);
		state_t r;
		r = s;
		for (int n = 0; n < NPTR; n++)
		begin
			if (a == ptr_lo_addr(n))
				r.ptr[n][BYTE_W-1:0] = d;
			if (a == ptr_hi_addr(n))
				r.ptr[n][ADDR_W-1:BYTE_W] = d[HI_W-1:0];
		end
		if (a == ADDR_WORK)
			r.work = d;
		if (a == ADDR_BANK)
			r.bank = d[BANK_W-1:0];
		return r;
	endfunction : local_write

	// Register bus address decode
	function automatic logic reg_mapped(input logic [7:0] a);
		logic hit;
		hit = (a == REG_BANK) || (a == REG_WORK) || (a == REG_CTRL) || (a == REG_LAST);
		for (int n = 0; n < NPTR; n++)
			hit = hit || (a == REG_PTR[n]);
		return hit;
	endfunction : reg_mapped

	// Register bus write with byte lanes
	function automatic state_t axi_write(input state_t s);
		state_t r;
		r = s;
		r.bresp = reg_mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
		for (int n = 0; n < NPTR; n++)
			if (s.awaddr == REG_PTR[n])
			begin
				if (s.wstrb[LANE_LO])
					r.ptr[n][BYTE_W-1:0] = s.wdata[BYTE_W-1:0];
				if (s.wstrb[LANE_HI])
					r.ptr[n][ADDR_W-1:BYTE_W] = s.wdata[ADDR_W-1:BYTE_W];
			end
		if (s.awaddr == REG_BANK && s.wstrb[LANE_LO])
			r.bank = s.wdata[BANK_W-1:0];
		if (s.awaddr == REG_WORK && s.wstrb[LANE_LO])
			r.work = s.wdata[BYTE_W-1:0];
		if (s.awaddr == REG_CTRL && s.wstrb[LANE_LO])
			r.ext_en = s.wdata[CTRL_EXT_BIT];
		return r;
	endfunction : axi_write

	// Register bus read: response above the data word
	function automatic logic [33:0] axi_read(input logic [7:0] a);
		logic [33:0] r;
		r = {reg_mapped(a) ? RESP_OKAY : RESP_SLVERR, WORD_ZERO};
		for (int n = 0; n < NPTR; n++)
			if (a == REG_PTR[n])
				r = {RESP_OKAY, 32'(s_q.ptr[n])};
		if (a == REG_BANK)
			r = {RESP_OKAY, 32'(s_q.bank)};
		if (a == REG_WORK)
			r = {RESP_OKAY, 32'(s_q.work)};
		if (a == REG_CTRL)
			r = {RESP_OKAY, 32'(s_q.ext_en)};
		if (a == REG_LAST)
			r = {RESP_OKAY, 32'(s_q.last_ea)};
		return r;
	endfunction : axi_read

	////////////////////////////////////////////////////////////////////////////////
	// Address path
	assign op_d    = i_acc_opcode[OP_D_BIT];
	assign op_a    = i_acc_opcode[OP_A_BIT];
	assign op_file = i_acc_opcode[OP_F_MSB:0];

	dag_file_map u_file_map (
		.i_file (op_file),
		.i_a    (op_a),
		.i_ext  (s_q.ext_en),
		.i_bank (s_q.bank),
		.i_base (s_q.ptr[PAIR_2]),
		.o_ea   (first_ea)
	);

	// Any reach of a virtual location stays an ordinary indirect access
	assign vm_first = virt_decode(first_ea);
	assign sel_ptr  = vm_first.hit ? s_q.ptr[vm_first.pair] : s_q.ptr[0];

	dag_ptr_step u_ptr_step (
		.i_ptr    (sel_ptr),
		.i_mode   (vm_first.mode),
		.i_work   (s_q.work),
		.o_target (step_target),
		.o_next   (step_next)
	);

	// Second level, own-pair write and update enables
	assign vm_second   = virt_decode(step_target);
	assign req_file    = i_acc_valid && (i_acc_kind == KIND_FILE);
	assign ind         = req_file && vm_first.hit;
	assign own_hit     = i_acc_write && (step_target == ptr_lo_addr(vm_first.pair) ||
	                     step_target == ptr_hi_addr(vm_first.pair));
	assign upd_en      = ind && !own_hit;
	assign eff_ea      = vm_first.hit ? step_target : first_ea;
	assign eff_null    = vm_first.hit && vm_second.hit;
	assign axi_wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign hw_quiet    = !i_wb_valid && !axi_wr_fire;

	// Local SFR lookup; a process so that a register change alone re-evaluates it
	always_comb
	begin
		loc = local_read(eff_ea);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: pointer step, then write-back, then register bus
	always_comb
	begin
		s_d = s_q;
		if (upd_en)
			s_d.ptr[vm_first.pair] = step_next;
		if (i_wb_valid)
			s_d = local_write(s_d, i_wb_addr, i_wb_data);
		s_d.rsp_valid   = i_acc_valid;
		s_d.rsp_addr    = req_file ? eff_ea : ADDR_NONE;
		s_d.rsp_null    = req_file && eff_null;
		s_d.rsp_local   = req_file && !eff_null && loc[BYTE_W];
		s_d.rsp_mem     = req_file && !eff_null && !loc[BYTE_W];
		s_d.rsp_we      = req_file && !eff_null && i_acc_write;
		s_d.rsp_data    = (req_file && !eff_null) ? loc[BYTE_W-1:0] : BYTE_ZERO;
		s_d.rsp_to_file = req_file && op_d;
		s_d.rsp_add     = req_file && i_acc_opcode[OP_GRP_MSB:OP_GRP_LSB] == OP_ADD_GRP;
		s_d.rsp_illegal = i_acc_valid && i_acc_kind == KIND_EXT && !s_q.ext_en;
		if (req_file)
			s_d.last_ea = eff_ea;
		if (i_awvalid && s_q.awready)
		begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = i_awaddr;
		end
		if (i_wvalid && s_q.wready)
		begin
			s_d.w_got = 1'b1;
			s_d.wdata = i_wdata;
			s_d.wstrb = i_wstrb;
		end
		if (s_q.bvalid && i_bready)
			s_d.bvalid = 1'b0;
		if (axi_wr_fire)
		begin
			s_d        = axi_write(s_d);
			s_d.bvalid = 1'b1;
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
		end
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready  = !s_d.w_got && !s_d.bvalid;
		if (i_arvalid && s_q.arready)
		begin
			s_d.rvalid             = 1'b1;
			{s_d.rresp, s_d.rdata} = axi_read(i_araddr);
		end
		else if (s_q.rvalid && i_rready)
			s_d.rvalid = 1'b0;
		s_d.arready = !s_d.rvalid;
	end

	// State register
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign o_rsp_valid   = s_q.rsp_valid;
	assign o_rsp_addr    = s_q.rsp_addr;
	assign o_rsp_mem     = s_q.rsp_mem;
	assign o_rsp_local   = s_q.rsp_local;
	assign o_rsp_null    = s_q.rsp_null;
	assign o_rsp_we      = s_q.rsp_we;
	assign o_rsp_data    = s_q.rsp_data;
	assign o_rsp_to_file = s_q.rsp_to_file;
	assign o_rsp_illegal = s_q.rsp_illegal;
	assign o_rsp_add     = s_q.rsp_add;
	assign o_awready     = s_q.awready;
	assign o_wready      = s_q.wready;
	assign o_bvalid      = s_q.bvalid;
	assign o_bresp       = s_q.bresp;
	assign o_arready     = s_q.arready;
	assign o_rvalid      = s_q.rvalid;
	assign o_rdata       = s_q.rdata;
	assign o_rresp       = s_q.rresp;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	chk_post_dec_step : assert property (
		upd_en && vm_first.mode == VM_PTR_AFTER_DECREMENT_OPERAND && hw_quiet |=>
		s_q.ptr[$past(vm_first.pair)] == $past(sel_ptr) - ADDR_ONE &&
		o_rsp_addr == $past(sel_ptr))
		else $error("after-decrement operand wrong");

	chk_post_inc_step : assert property (
		upd_en && vm_first.mode == VM_PTR_AFTER_INCREMENT_OPERAND && hw_quiet |=>
		s_q.ptr[$past(vm_first.pair)] == $past(sel_ptr) + ADDR_ONE &&
		o_rsp_addr == $past(sel_ptr))
		else $error("after-increment operand wrong");

	chk_pre_inc_step : assert property (
		upd_en && vm_first.mode == VM_PTR_BEFORE_INCREMENT_OPERAND |=> o_rsp_addr == $past(sel_ptr) + ADDR_ONE)
		else $error("before-increment operand wrong");

	chk_plus_work : assert property (
		ind && vm_first.mode == VM_PTR_PLUS_WORKING_OPERAND && hw_quiet |=>
		o_rsp_addr == $past(sel_ptr + {{4{s_q.work[7]}}, s_q.work}) && s_q.ptr == $past(s_q.ptr))
		else $error("plus-working operand wrong");

	chk_pair_carry : assert property (
		upd_en && vm_first.mode == VM_PTR_AFTER_INCREMENT_OPERAND && sel_ptr[7:0] == 8'hff && hw_quiet |=>
		s_q.ptr[$past(vm_first.pair)][7:0] == 8'h00 &&
		s_q.ptr[$past(vm_first.pair)][11:8] == $past(sel_ptr[11:8]) + 4'h1)
		else $error("pair carry lost");

	chk_virtual_null : assert property (
		o_rsp_null |-> o_rsp_data == BYTE_ZERO && !o_rsp_mem && !o_rsp_we && !o_rsp_local)
		else $error("virtual target not nulled");

	chk_own_no_step : assert property (
		ind && own_hit && hw_quiet |=> s_q.ptr == $past(s_q.ptr))
		else $error("own pair stepped on write");

	chk_indexed_window : assert property (
		req_file && s_q.ext_en && !op_a && op_file <= ILO_LIMIT && !vm_first.hit |=>
		o_rsp_addr == $past(s_q.ptr[PAIR_2] + {ACCESS_PAGE, op_file}))
		else $error("indexed offset address wrong");

	chk_forced_page : assert property (
		req_file && !op_a && op_file >= FORCED_LOW && !vm_first.hit |=>
		o_rsp_addr == {FORCED_PAGE, $past(op_file)})
		else $error("forced page address wrong");

	chk_bank_direct : assert property (
		req_file && op_a && !vm_first.hit |=> o_rsp_addr == $past({s_q.bank, op_file}))
		else $error("banked address wrong");

	chk_ext_gate : assert property (
		i_acc_valid && i_acc_kind == KIND_EXT |=> o_rsp_illegal == !$past(s_q.ext_en))
		else $error("extended op gating wrong");

	cov_post_inc : cover property (upd_en && vm_first.mode == VM_PTR_AFTER_INCREMENT_OPERAND);
	cov_indexed  : cover property (req_file && s_q.ext_en && !op_a && op_file <= ILO_LIMIT);
	cov_null     : cover property (o_rsp_null);
	cov_axi_wr   : cover property (axi_wr_fire ##[1:4] (o_bvalid && i_bready));

endmodule : data_address_generation

// *** test/core_model.sv ***
// Decoder and execute stage model on the core side of the block
`timescale 1ns/1ps
module core_model
	import dag_pkg::*;
(
	input  wire logic   i_clk,        // Core clock
	output logic        o_acc_valid,  // Instruction strobe
	output kind_t       o_acc_kind,   // Instruction class
	output logic [15:0] o_acc_opcode, // First opcode word
	output logic        o_acc_write,  // Instruction writes target
	output logic        o_wb_valid,   // SFR write strobe
	output addr_t       o_wb_addr,    // SFR write address
	output byte_t       o_wb_data     // SFR write data
);
	// Idle opcode, write, address and data lines carry the inverse of their last value; strobes drop and the kind goes to KIND_NONE
	initial
	begin
		o_acc_valid = 1'b0;
		o_acc_kind = KIND_NONE;
		o_acc_opcode = 16'h0000;
		o_acc_write = 1'b0;
		o_wb_valid = 1'b0;
		o_wb_addr = 12'h000;
		o_wb_data = 8'h00;
	end

	// One instruction for one cycle
	task issue(input kind_t k, input logic [15:0] op, input logic wr);
		@(posedge i_clk);
		o_acc_valid <= 1'b1;
		o_acc_kind <= k;
		o_acc_opcode <= op;
		o_acc_write <= wr;
		@(posedge i_clk);
		o_acc_valid <= 1'b0;
		o_acc_kind <= KIND_NONE;
		o_acc_opcode <= ~op;
		o_acc_write <= ~wr;
	endtask : issue

	// One execute stage SFR write
	task wb(input addr_t a, input byte_t d);
		@(posedge i_clk);
		o_wb_valid <= 1'b1;
		o_wb_addr <= a;
		o_wb_data <= d;
		@(posedge i_clk);
		o_wb_valid <= 1'b0;
		o_wb_addr <= ~a;
		o_wb_data <= ~d;
	endtask : wb
endmodule : core_model

// *** test/testbench.sv ***
// Self-checking bench for the data address generation block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench
	import dag_pkg::*;
;
	logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic arready, rvalid, acc_valid, acc_write, wb_valid, rsp_valid, rsp_null, rsp_we;
	logic rsp_to_file, rsp_illegal, rsp_add, rsp_mem, rsp_local;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] acc_opcode;
	kind_t acc_kind;
	addr_t wb_addr, rsp_addr;
	byte_t wb_data, rsp_data;
	int fail_count, check_count;

	data_address_generation DUT (
		.i_clk(clk), .i_arst_n(arst_n), .i_acc_valid(acc_valid), .i_acc_kind(acc_kind),
		.i_acc_opcode(acc_opcode), .i_acc_write(acc_write), .i_wb_valid(wb_valid),
		.i_wb_addr(wb_addr), .i_wb_data(wb_data), .o_rsp_valid(rsp_valid),
		.o_rsp_addr(rsp_addr), .o_rsp_mem(rsp_mem), .o_rsp_local(rsp_local),
		.o_rsp_null(rsp_null),
		.o_rsp_we(rsp_we), .o_rsp_data(rsp_data), .o_rsp_to_file(rsp_to_file),
		.o_rsp_illegal(rsp_illegal), .o_rsp_add(rsp_add), .i_awvalid(awvalid),
		.o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
		.i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
		.o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));

	core_model u_core (.i_clk(clk), .o_acc_valid(acc_valid), .o_acc_kind(acc_kind),
		.o_acc_opcode(acc_opcode), .o_acc_write(acc_write), .o_wb_valid(wb_valid),
		.o_wb_addr(wb_addr), .o_wb_data(wb_data));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 8 ns period
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task results;
		$display("checks %0d fails %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	// A used-up wait counts as a mismatch and closes the run
	task guard(input int n);
		if (n < 50)
			return;
		fail_count++;
		results;
	endtask : guard

	// Register write, address and data offered together
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !bvalid; n++)
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		guard(n);
		`CHK("bresp", er, bresp)
	endtask : axw

	// Register read, data left in rd
	task axr(input logic [7:0] a, input logic [1:0] er);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !rvalid; n++)
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		rd = rdata;
		guard(n);
		`CHK("rresp", er, rresp)
	endtask : axr

	// One file access, then the pointer pair read back
	task acc(input logic [15:0] op, input logic wr, input addr_t ea, input logic nul,
		input int p, input addr_t pe);
		logic lcl;
		lcl = ea inside {12'hfe9, 12'hfea, 12'hfe1, 12'hfe2, 12'hfd9, 12'hfda, 12'hfe8, 12'hfe0};
		u_core.issue(KIND_FILE, op, wr);
		#1;
		`CHK("rsp_valid", 1'b1, rsp_valid)
		`CHK("rsp_null", nul, rsp_null)
		`CHK("to_file", op[9], rsp_to_file)
		`CHK("add", op[15:10] == 6'b001001, rsp_add)
		if (nul)
		begin
			`CHK("rsp_we", 1'b0, rsp_we)
			`CHK("rsp_data", 8'h00, rsp_data)
		end
		else
		begin
			`CHK("rsp_addr", ea, rsp_addr)
			`CHK("rsp_we", wr, rsp_we)
		end
		`CHK("rsp_local", !nul && lcl, rsp_local)
		`CHK("rsp_mem", !nul && !lcl, rsp_mem)
		axr(REG_PTR[p], RESP_OKAY);
		`CHK("pointer", {20'h00000, pe}, rd)
	endtask : acc

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_regs;
		axr(REG_PTR[0], RESP_OKAY);
		`CHK("ptr reset", 32'h0000_0000, rd)
		axw(REG_PTR[0], 32'hffff_f5a5, RESP_OKAY);
		axr(REG_PTR[0], RESP_OKAY);
		`CHK("ptr width", 32'h0000_05a5, rd)
		axw(8'h1c, 32'h0000_0001, RESP_SLVERR);
		axr(8'h1c, RESP_SLVERR);
		u_core.wb(12'hfe9, 8'h3c);
		axr(REG_PTR[0], RESP_OKAY);
		`CHK("ptr by sfr", 32'h0000_053c, rd)
	endtask : t_regs

	task t_steps;
		axw(REG_PTR[1], 32'h0000_00ff, RESP_OKAY);
		acc(16'h24e6, 1'b0, 12'h0ff, 1'b0, 1, 12'h100);
		acc(16'h24e5, 1'b0, 12'h100, 1'b0, 1, 12'h0ff);
		acc(16'h24e4, 1'b0, 12'h100, 1'b0, 1, 12'h100);
		axw(REG_WORK, 32'h0000_00ff, RESP_OKAY);
		acc(16'h24e3, 1'b0, 12'h0ff, 1'b0, 1, 12'h100);
		acc(16'h24e7, 1'b0, 12'h100, 1'b0, 1, 12'h100);
		axw(REG_PTR[1], 32'h0000_0000, RESP_OKAY);
		acc(16'h24e3, 1'b0, 12'hfff, 1'b0, 1, 12'h000);
		acc(16'h24e5, 1'b0, 12'h000, 1'b0, 1, 12'hfff);
	endtask : t_steps

	task t_null;
		axw(REG_PTR[0], 32'h0000_0fe7, RESP_OKAY);
		acc(16'h24ef, 1'b0, 12'hfe7, 1'b1, 0, 12'hfe7);
		acc(16'h24ef, 1'b1, 12'hfe7, 1'b1, 0, 12'hfe7);
		axw(REG_PTR[2], 32'h0000_0fd9, RESP_OKAY);
		acc(16'h24de, 1'b1, 12'hfd9, 1'b0, 2, 12'hfd9);
	endtask : t_null

	task t_ext;
		u_core.issue(KIND_EXT, 16'he800, 1'b0);
		#1;
		`CHK("illegal off", 1'b1, rsp_illegal)
		axw(REG_CTRL, 32'h0000_0001, RESP_OKAY);
		u_core.issue(KIND_EXT, 16'he800, 1'b0);
		#1;
		`CHK("illegal on", 1'b0, rsp_illegal)
		u_core.issue(KIND_NONE, 16'h0e55, 1'b0);
		#1;
		`CHK("inherent", 12'h000, rsp_addr)
		axw(REG_PTR[2], 32'h0000_0200, RESP_OKAY);
		acc(16'h2410, 1'b0, 12'h210, 1'b0, 2, 12'h200);
		acc(16'h245f, 1'b0, 12'h25f, 1'b0, 2, 12'h200);
		acc(16'h2460, 1'b0, 12'hf60, 1'b0, 2, 12'h200);
		acc(16'h24df, 1'b0, 12'h200, 1'b0, 2, 12'h200);
		axw(REG_BANK, 32'h0000_0003, RESP_OKAY);
		acc(16'h2510, 1'b0, 12'h310, 1'b0, 2, 12'h200);
		acc(16'h5210, 1'b0, 12'h210, 1'b0, 2, 12'h200);
		axw(REG_PTR[0], 32'h0000_0123, RESP_OKAY);
		acc(16'h24ef, 1'b0, 12'h123, 1'b0, 0, 12'h123);
		axw(REG_PTR[2], 32'h0000_0ff0, RESP_OKAY);
		acc(16'h2620, 1'b0, 12'h010, 1'b0, 2, 12'hff0);
	endtask : t_ext

	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hf;
		fail_count = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_regs;
		t_steps;
		t_null;
		t_ext;
		results;
	end
endmodule : testbench
